// ### src/dlb_pkg.sv
// Constants and types for the defect-list and buffer-write command block
package dlb_pkg;

  // ==========================================================
  // Command codes and descriptor field positions
  localparam logic [7:0]  OP_RDD       = 8'h37;
  localparam logic [7:0]  OP_WBUF      = 8'h3B;
  localparam logic [3:0]  CDB_LAST_IDX = 4'h9;
  localparam int          RDD_P_BIT    = 4;
  localparam int          RDD_G_BIT    = 3;
  localparam logic [2:0]  FMT_BLOCK    = 3'h0;
  localparam logic [1:0]  MODE_COMB    = 2'h0;
  localparam logic [7:0]  BUF_ID_ZERO  = 8'h00;

  // ==========================================================
  // Lengths and sizes
  localparam logic [15:0] HDR_LEN      = 16'h0004;
  localparam logic [23:0] WB_HDR       = 24'h000004;
  localparam logic [2:0]  DMAX_SHORT   = 3'h3;
  localparam logic [2:0]  DMAX_LONG    = 3'h7;
  localparam int          NUM_DEF      = 8;
  localparam int          BUF_LEN      = 64;
  localparam logic [23:0] BUF_AVAIL    = 24'h000040;
  localparam logic [23:0] WB_MAX       = BUF_AVAIL + WB_HDR;
  localparam logic [3:0]  DECODE_BYTES = 4'h6;

  // ==========================================================
  // Sense keys
  localparam logic [3:0]  SENSE_NONE   = 4'h0;
  localparam logic [3:0]  SENSE_ILL    = 4'h5;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_DEF_IDX  = 8'h08;
  localparam logic [7:0]  REG_DEF_LO   = 8'h0C;
  localparam logic [7:0]  REG_DEF_HI   = 8'h10;
  localparam logic [7:0]  REG_DEF_TAG  = 8'h14;
  localparam logic [7:0]  REG_BUF_IDX  = 8'h18;
  localparam logic [7:0]  REG_BUF_DATA = 8'h1C;
  localparam logic [1:0]  CTRL_RST     = 2'h3;

  // ==========================================================
  // Command sequencer states
  typedef enum logic [3:0] {
    S_IDLE      = 4'h1,
    S_RDD_SEND  = 4'h2,
    S_RDD_DRAIN = 4'h4,
    S_WB_DATA   = 4'h8
  } dlb_state_t;

endpackage : dlb_pkg

// ### src/dlb_cdb_capture.sv
// Command descriptor byte capture
`timescale 1ns/1ps
module dlb_cdb_capture (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_last,
  output logic             o_stb,
  output logic [3:0]       o_idx,
  output logic             o_done,
  output logic [79:0]      o_cdb
);
  logic [3:0]  idx_reg;
  logic        done_reg;
  logic [79:0] cdb_reg;

  assign o_stb  = i_valid & i_ce;
  assign o_idx  = idx_reg;
  assign o_done = done_reg;
  assign o_cdb  = cdb_reg;

  // ==========================================================
  // Byte collection; bytes past ten overwrite the tenth byte
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      idx_reg  <= 4'h0;
      done_reg <= 1'b0;
      cdb_reg  <= 80'h0;
    end else if (i_ce) begin
      done_reg <= i_valid & i_last;
      if (i_valid) begin
        if (idx_reg <= dlb_pkg::CDB_LAST_IDX) begin
          cdb_reg[{idx_reg, 3'h0} +: 8] <= i_byte;
        end
        if (i_last) begin
          idx_reg <= 4'h0;
        end else if (idx_reg < dlb_pkg::CDB_LAST_IDX) begin
          idx_reg <= idx_reg + 4'h1;
        end
      end
    end
  end

endmodule : dlb_cdb_capture

// ### src/dlb_sel_count.sv
// Defect entry selection and count
`timescale 1ns/1ps
module dlb_sel_count (
  input  wire logic [dlb_pkg::NUM_DEF-1:0] i_valid,
  input  wire logic [dlb_pkg::NUM_DEF-1:0] i_grown,
  input  wire logic                        i_want_p,
  input  wire logic                        i_want_g,
  output logic [dlb_pkg::NUM_DEF-1:0]      o_sel,
  output logic [3:0]                       o_count
);
  always_comb begin
    o_sel   = '0;
    o_count = 4'h0;
    for (int k = 0; k < dlb_pkg::NUM_DEF; k++) begin
      o_sel[k] = i_valid[k] & (i_grown[k] ? i_want_g : i_want_p);
      o_count  = o_count + {3'h0, o_sel[k]};
    end
  end

endmodule : dlb_sel_count

// ### src/dlb_cmd_core.sv
// Defect-data read and buffer-write command interpreter
`timescale 1ns/1ps
module dlb_cmd_core (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_cdb_valid,
  input  wire logic [7:0]  i_cdb_byte,
  input  wire logic        i_cdb_last,
  output logic             o_din_valid,
  output logic [7:0]       o_din_data,
  input  wire logic        i_din_ready,
  input  wire logic        i_dout_valid,
  input  wire logic [7:0]  i_dout_data,
  output logic             o_dout_ready,
  output logic             o_cmd_done,
  output logic             o_check_cond,
  output logic [3:0]       o_sense_key,
  output logic             o_busy
);
  // ==========================================================
  // Declarations
  dlb_pkg::dlb_state_t state_reg;
  logic [79:0] cdb;
  logic        cap_stb;
  logic        cap_done;
  logic [3:0]  cap_idx;
  logic [7:0]  op;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [15:0] alloc;
  logic [23:0] xoff;
  logic [23:0] xlen;
  logic        want_p;
  logic        want_g;
  logic        long_fmt;
  logic [7:0]  sel_mask;
  logic [3:0]  sel_cnt;
  logic [15:0] len_calc;
  logic [15:0] total;
  logic [15:0] limit_calc;
  logic        wb_bad;
  logic        start;
  logic [1:0]  ctrl_reg;
  logic [2:0]  def_idx_reg;
  logic [5:0]  buf_idx_reg;
  logic [31:0] def_lo  [dlb_pkg::NUM_DEF];
  logic [31:0] def_hi  [dlb_pkg::NUM_DEF];
  logic [1:0]  def_tag [dlb_pkg::NUM_DEF];
  logic [7:0]  buf_mem [dlb_pkg::BUF_LEN];
  logic [7:0]  tag_valid;
  logic [7:0]  tag_grown;
  logic        ack_reg;
  logic        req;
  logic        wr_now;
  logic [31:0] rd_reg;
  logic        done_reg;
  logic        check_reg;
  logic [3:0]  sense_reg;
  logic [7:0]  last_op_reg;
  logic [15:0] limit_reg;
  logic [15:0] list_len_reg;
  logic [15:0] sent_reg;
  logic [3:0]  ent_reg;
  logic [2:0]  bsel_reg;
  logic [7:0]  sel_reg;
  logic        long_reg;
  logic        ret_p_reg;
  logic        ret_g_reg;
  logic [2:0]  fmt_reg;
  logic        din_valid_reg;
  logic [7:0]  din_data_reg;
  logic [15:0] din_pos_reg;
  logic        slot_free;
  logic        emit;
  logic        adv_ent;
  logic [7:0]  out_byte;
  logic [2:0]  dmax;
  logic [63:0] word;
  logic [63:0] shifted;
  logic [23:0] wb_len_reg;
  logic [23:0] wb_cnt_reg;
  logic [23:0] wb_off;
  logic        dout_fire;

  dlb_cdb_capture u_cap (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_valid   (i_cdb_valid),
    .i_byte    (i_cdb_byte),
    .i_last    (i_cdb_last),
    .o_stb     (cap_stb),
    .o_idx     (cap_idx),
    .o_done    (cap_done),
    .o_cdb     (cdb)
  );

  // ==========================================================
  // Command field decode
  assign op    = cdb[7:0];
  assign b1    = cdb[15:8];
  assign b2    = cdb[23:16];
  assign alloc = {cdb[63:56], cdb[71:64]};
  assign xoff  = {cdb[31:24], cdb[39:32], cdb[47:40]};
  assign xlen  = {cdb[55:48], cdb[63:56], cdb[71:64]};
  // Returned lists are requested ones that software marks present
  assign want_p   = b2[dlb_pkg::RDD_P_BIT] & ctrl_reg[0];
  assign want_g   = b2[dlb_pkg::RDD_G_BIT] & ctrl_reg[1];
  assign long_fmt = b2[2:0] != dlb_pkg::FMT_BLOCK;
  assign start    = (state_reg == dlb_pkg::S_IDLE) & cap_done & i_ce;

  always_comb begin
    for (int k = 0; k < dlb_pkg::NUM_DEF; k++) begin
      tag_valid[k] = def_tag[k][0];
      tag_grown[k] = def_tag[k][1];
    end
  end

  dlb_sel_count u_sel (
    .i_valid  (tag_valid),
    .i_grown  (tag_grown),
    .i_want_p (want_p),
    .i_want_g (want_g),
    .o_sel    (sel_mask),
    .o_count  (sel_cnt)
  );

  // Zero selected entries gives a header-only answer
  assign len_calc = long_fmt ? {9'h000, sel_cnt, 3'h0}
                             : {10'h000, sel_cnt, 2'h0};
  assign total      = len_calc + dlb_pkg::HDR_LEN;
  assign limit_calc = (alloc < total) ? alloc : total;
  // Mode, buffer id, offset and length must all be acceptable
  assign wb_bad = (b1[1:0] != dlb_pkg::MODE_COMB)
                | (b2 != dlb_pkg::BUF_ID_ZERO)
                | (xoff != 24'h000000)
                | (xlen > dlb_pkg::WB_MAX);

  // ==========================================================
  // Sequencer and completion status
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg   <= dlb_pkg::S_IDLE;
      done_reg    <= 1'b0;
      check_reg   <= 1'b0;
      sense_reg   <= dlb_pkg::SENSE_NONE;
      last_op_reg <= 8'h00;
    end else if (i_ce) begin
      done_reg <= 1'b0;
      unique case (state_reg)
        dlb_pkg::S_IDLE: begin
          if (cap_done && op == dlb_pkg::OP_RDD) begin
            last_op_reg <= op;
            check_reg   <= 1'b0;
            sense_reg   <= dlb_pkg::SENSE_NONE;
            if (alloc == 16'h0000) begin
              done_reg <= 1'b1;
            end else begin
              state_reg <= dlb_pkg::S_RDD_SEND;
            end
          end else if (cap_done && op == dlb_pkg::OP_WBUF) begin
            last_op_reg <= op;
            if (wb_bad) begin
              done_reg  <= 1'b1;
              check_reg <= 1'b1;
              sense_reg <= dlb_pkg::SENSE_ILL;
            end else begin
              check_reg <= 1'b0;
              sense_reg <= dlb_pkg::SENSE_NONE;
              if (xlen == 24'h000000) begin
                done_reg <= 1'b1;
              end else begin
                state_reg <= dlb_pkg::S_WB_DATA;
              end
            end
          end
        end
        dlb_pkg::S_RDD_SEND: begin
          if (slot_free && sent_reg == limit_reg) begin
            state_reg <= dlb_pkg::S_RDD_DRAIN;
          end
        end
        dlb_pkg::S_RDD_DRAIN: begin
          if (slot_free) begin
            done_reg  <= 1'b1;
            state_reg <= dlb_pkg::S_IDLE;
          end
        end
        dlb_pkg::S_WB_DATA: begin
          if (dout_fire && wb_cnt_reg == wb_len_reg - 24'h000001) begin
            done_reg  <= 1'b1;
            state_reg <= dlb_pkg::S_IDLE;
          end
        end
        default: begin
          state_reg <= dlb_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign o_cmd_done   = done_reg;
  assign o_check_cond = check_reg;
  assign o_sense_key  = sense_reg;
  assign o_busy       = state_reg != dlb_pkg::S_IDLE;

  // ==========================================================
  // Defect data generator
  assign slot_free = ~din_valid_reg | i_din_ready;
  assign dmax      = long_reg ? dlb_pkg::DMAX_LONG : dlb_pkg::DMAX_SHORT;
  // Entries go out in table order; any order is legal
  assign word    = long_reg ? {def_hi[ent_reg[2:0]], def_lo[ent_reg[2:0]]}
                            : {32'h0, def_lo[ent_reg[2:0]]};
  assign shifted = word >> {dmax - bsel_reg, 3'h0};

  always_comb begin
    emit     = 1'b0;
    adv_ent  = 1'b0;
    out_byte = 8'h00;
    unique case (sent_reg[1:0])
      2'h0: out_byte = 8'h00;
      2'h1: out_byte = {3'h0, ret_p_reg, ret_g_reg, fmt_reg};
      2'h2: out_byte = list_len_reg[15:8];
      2'h3: out_byte = list_len_reg[7:0];
    endcase
    if (state_reg == dlb_pkg::S_RDD_SEND && slot_free
        && sent_reg != limit_reg) begin
      if (sent_reg < dlb_pkg::HDR_LEN) begin
        emit = 1'b1;
      end else if (!ent_reg[3] && sel_reg[ent_reg[2:0]]) begin
        emit     = 1'b1;
        out_byte = shifted[7:0];
        adv_ent  = bsel_reg == dmax;
      end else begin
        adv_ent = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      limit_reg    <= 16'h0000;
      list_len_reg <= 16'h0000;
      sent_reg     <= 16'h0000;
      ent_reg      <= 4'h0;
      bsel_reg     <= 3'h0;
      sel_reg      <= 8'h00;
      long_reg     <= 1'b0;
      ret_p_reg    <= 1'b0;
      ret_g_reg    <= 1'b0;
      fmt_reg      <= 3'h0;
    end else if (i_ce) begin
      if (start && op == dlb_pkg::OP_RDD) begin
        limit_reg    <= limit_calc;
        list_len_reg <= len_calc;
        sent_reg     <= 16'h0000;
        ent_reg      <= 4'h0;
        bsel_reg     <= 3'h0;
        sel_reg      <= sel_mask;
        long_reg     <= long_fmt;
        ret_p_reg    <= want_p;
        ret_g_reg    <= want_g;
        fmt_reg      <= b2[2:0];
      end else begin
        if (emit) begin
          sent_reg <= sent_reg + 16'h0001;
        end
        if (adv_ent) begin
          ent_reg  <= ent_reg + 4'h1;
          bsel_reg <= 3'h0;
        end else if (emit && sent_reg >= dlb_pkg::HDR_LEN) begin
          bsel_reg <= bsel_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      din_valid_reg <= 1'b0;
      din_data_reg  <= 8'h00;
      din_pos_reg   <= 16'h0000;
    end else if (i_ce && slot_free) begin
      din_valid_reg <= emit;
      if (emit) begin
        din_data_reg <= out_byte;
        din_pos_reg  <= sent_reg;
      end
    end
  end

  // Frozen output holds valid at its last value while clock enable is low
  assign o_din_valid = din_valid_reg;
  assign o_din_data  = din_data_reg;

  // ==========================================================
  // Buffer write data path; no path leads to the medium
  assign o_dout_ready = (state_reg == dlb_pkg::S_WB_DATA) & i_ce;
  assign dout_fire    = o_dout_ready & i_dout_valid;
  assign wb_off       = wb_cnt_reg - dlb_pkg::WB_HDR;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wb_len_reg <= 24'h000000;
      wb_cnt_reg <= 24'h000000;
    end else if (i_ce) begin
      if (start && op == dlb_pkg::OP_WBUF) begin
        wb_len_reg <= xlen;
        wb_cnt_reg <= 24'h000000;
      end else if (dout_fire) begin
        wb_cnt_reg <= wb_cnt_reg + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < dlb_pkg::BUF_LEN; k++) begin
        buf_mem[k] <= 8'h00;
      end
    end else if (i_ce) begin
      if (cap_stb && cap_idx < dlb_pkg::DECODE_BYTES) begin
        buf_mem[{2'h0, cap_idx}] <= i_cdb_byte;
      end else if (dout_fire && wb_cnt_reg >= dlb_pkg::WB_HDR) begin
        buf_mem[wb_off[5:0]] <= i_dout_data;
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~(ack_reg & i_ce);
  assign wr_now            = i_avs_write & ack_reg & i_ce;
  assign o_avs_readdata    = rd_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
      rd_reg  <= 32'h00000000;
    end else if (i_ce) begin
      ack_reg <= req & ~ack_reg;
      if (i_avs_read && !ack_reg) begin
        unique case (i_avs_address)
          dlb_pkg::REG_CTRL:     rd_reg <= {30'h0, ctrl_reg};
          dlb_pkg::REG_STATUS:   rd_reg <= {16'h0, last_op_reg, sense_reg,
                                            2'h0, o_busy, check_reg};
          dlb_pkg::REG_DEF_IDX:  rd_reg <= {29'h0, def_idx_reg};
          dlb_pkg::REG_DEF_LO:   rd_reg <= def_lo[def_idx_reg];
          dlb_pkg::REG_DEF_HI:   rd_reg <= def_hi[def_idx_reg];
          dlb_pkg::REG_DEF_TAG:  rd_reg <= {30'h0, def_tag[def_idx_reg]};
          dlb_pkg::REG_BUF_IDX:  rd_reg <= {26'h0, buf_idx_reg};
          dlb_pkg::REG_BUF_DATA: rd_reg <= {24'h0, buf_mem[buf_idx_reg]};
          default:               rd_reg <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg    <= dlb_pkg::CTRL_RST;
      def_idx_reg <= 3'h0;
      buf_idx_reg <= 6'h00;
      for (int k = 0; k < dlb_pkg::NUM_DEF; k++) begin
        def_lo[k]  <= 32'h00000000;
        def_hi[k]  <= 32'h00000000;
        def_tag[k] <= 2'h0;
      end
    end else if (wr_now && i_avs_byteenable[0]) begin
      unique case (i_avs_address)
        dlb_pkg::REG_CTRL:    ctrl_reg    <= i_avs_writedata[1:0];
        dlb_pkg::REG_DEF_IDX: def_idx_reg <= i_avs_writedata[2:0];
        dlb_pkg::REG_DEF_TAG: def_tag[def_idx_reg] <= i_avs_writedata[1:0];
        dlb_pkg::REG_BUF_IDX: buf_idx_reg <= i_avs_writedata[5:0];
        dlb_pkg::REG_DEF_LO:  def_lo[def_idx_reg] <= i_avs_writedata;
        dlb_pkg::REG_DEF_HI:  def_hi[def_idx_reg] <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_rdd_start;
    start && op == dlb_pkg::OP_RDD;
  endsequence
  sequence s_wb_start;
    start && op == dlb_pkg::OP_WBUF;
  endsequence
  sequence s_ill_done;
    o_cmd_done && o_check_cond && o_sense_key == dlb_pkg::SENSE_ILL
      && state_reg == dlb_pkg::S_IDLE;
  endsequence

  property p_alloc_zero;
    s_rdd_start and (alloc == 16'h0000) |=>
      o_cmd_done && !o_check_cond && !o_din_valid;
  endproperty
  a_alloc_zero: assert property (p_alloc_zero)
    else $error("zero allocation did not end cleanly");

  property p_hdr_only;
    s_rdd_start and (!want_p && !want_g) |=> list_len_reg == 16'h0000;
  endproperty
  a_hdr_only: assert property (p_hdr_only)
    else $error("header-only answer carries descriptors");

  property p_ret_bits;
    s_rdd_start |=> ret_p_reg == $past(want_p) && ret_g_reg == $past(want_g)
      && limit_reg <= list_len_reg + dlb_pkg::HDR_LEN;
  endproperty
  a_ret_bits: assert property (p_ret_bits)
    else $error("returned indicators or limit wrong");

  property p_cap;
    (state_reg == dlb_pkg::S_RDD_SEND) |-> sent_reg <= limit_reg;
  endproperty
  a_cap: assert property (p_cap)
    else $error("defect data overran the limit");

  property p_hdr_len;
    o_din_valid && din_pos_reg == 16'h0002 |->
      o_din_data == list_len_reg[15:8];
  endproperty
  a_hdr_len: assert property (p_hdr_len)
    else $error("list length byte wrong");

  property p_no_check;
    o_cmd_done && last_op_reg == dlb_pkg::OP_RDD |-> !o_check_cond;
  endproperty
  a_no_check: assert property (p_no_check)
    else $error("defect read raised a check");

  property p_bad_mode;
    s_wb_start and (b1[1:0] != dlb_pkg::MODE_COMB) |=> s_ill_done;
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("unsupported mode not rejected");

  property p_too_long;
    s_wb_start and (xlen > dlb_pkg::WB_MAX) |=> s_ill_done ##1 !o_busy;
  endproperty
  a_too_long: assert property (p_too_long)
    else $error("overlong buffer write not rejected");

  property p_store;
    dout_fire && wb_cnt_reg >= dlb_pkg::WB_HDR && !cap_stb |=>
      buf_mem[$past(wb_off[5:0])] == $past(i_dout_data);
  endproperty
  a_store: assert property (p_store)
    else $error("buffer byte not stored");

  property p_decode_bytes;
    cap_stb && cap_idx < dlb_pkg::DECODE_BYTES |=>
      buf_mem[{2'h0, $past(cap_idx)}] == $past(i_cdb_byte);
  endproperty
  a_decode_bytes: assert property (p_decode_bytes)
    else $error("command byte not placed in buffer");

endmodule : dlb_cmd_core

// ### tb/dlb_init.sv
// Initiator model: command bytes, data-in sink, data-out source
`timescale 1ns/1ps
module dlb_init (
  input  wire logic       i_clk,
  input  wire logic       i_din_valid,
  input  wire logic [7:0] i_din_data,
  input  wire logic       i_dout_ready,
  output logic            o_cdb_valid,
  output logic [7:0]      o_cdb_byte,
  output logic            o_cdb_last,
  output logic            o_din_ready,
  output logic            o_dout_valid,
  output logic [7:0]      o_dout_data
);
  logic [7:0] q[$];
  initial begin
    o_cdb_valid = 1'b0;
    o_cdb_byte = 8'h00;
    o_cdb_last = 1'b0;
    o_din_ready = 1'b0;
    o_dout_valid = 1'b1;
    o_dout_data = 8'hA0;
  end
  // ==========================================================
  // Ready toggles so the device sees a slow taker
  always @(posedge i_clk) begin
    o_din_ready <= ~o_din_ready;
    if (i_din_valid && o_din_ready) q.push_back(i_din_data);
    if (i_dout_ready) o_dout_data <= o_dout_data + 8'h01;
  end
  // Byte 0 first; line shows junk once released
  task send(input logic [79:0] c);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_cdb_valid <= 1'b1;
      o_cdb_byte <= c[79-8*i -: 8];
      o_cdb_last <= (i == 9);
    end
    @(posedge i_clk);
    o_cdb_valid <= 1'b0;
    o_cdb_last <= 1'b0;
    o_cdb_byte <= ~o_cdb_byte;
  endtask : send
endmodule : dlb_init

// ### tb/defect_list_and_buffer_cmds_bench.sv
// Self-checking bench for the command block
`timescale 1ns/1ps
module defect_list_and_buffer_cmds_bench;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rv;
  logic dv, dr, ov, orr, cv, cl, done, ck, busy;
  logic [7:0] dd, od, cb;
  logic [31:0] rdat;
  logic [3:0] sk;
  logic waitreq;
  int miscompares = 0, total_checks = 0, cyc = 0;
  always #20 i_clk = ~i_clk;
  dlb_init P (.i_clk(i_clk), .i_din_valid(dv), .i_din_data(dd),
    .i_dout_ready(orr), .o_cdb_valid(cv), .o_cdb_byte(cb), .o_cdb_last(cl),
    .o_din_ready(dr), .o_dout_valid(ov), .o_dout_data(od));
  dlb_cmd_core DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
    .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(waitreq), .i_cdb_valid(cv), .i_cdb_byte(cb),
    .i_cdb_last(cl), .o_din_valid(dv), .o_din_data(dd), .i_din_ready(dr),
    .i_dout_valid(ov), .i_dout_data(od), .o_dout_ready(orr),
    .o_cmd_done(done), .o_check_cond(ck), .o_sense_key(sk), .o_busy(busy));
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test;
    end
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // ==========================================================
  // Bus cycle: hold until waitrequest sampled low
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge i_clk); while (waitreq !== 1'b0);
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  task cmd(input logic [79:0] c, input int n, input logic [63:0] e,
           input logic k);
    P.q.delete();
    P.send(c);
    repeat (300) begin
      @(posedge i_clk);
      if (done === 1'b1) break;
    end
    chk("done", done, 1'b1);
    chk("busy", busy, 1'b0);
    chk("bytes", P.q.size(), n);
    chk("check", ck, k);
    chk("sense", sk, k ? 4'h5 : 4'h0);
    for (int i = 0; i < n; i++) chk("din", P.q[i], e[63-8*i -: 8]);
  endtask : cmd
  task t_defect;
    av(1'b0, 8'h00, 32'h0);
    chk("ctrl", rv, 32'h3);
    av(1'b0, 8'h40, 32'h0);
    chk("unmapped", rv, 32'h0);
    for (int i = 0; i < 8; i++) begin
      av(1'b1, 8'h08, i);
      av(1'b1, 8'h0C, 32'h11223344 + i);
      av(1'b1, 8'h10, 32'h55667700 + i);
      av(1'b1, 8'h14, (i == 0) ? 32'h1 : ((i == 1) ? 32'h3 : 32'h0));
    end
    cmd(80'h3700_1000_0000_0000_6400, 8, 64'h0010_0004_1122_3344, 0);
    cmd(80'h3700_0800_0000_0000_6400, 8, 64'h0008_0004_1122_3345, 0);
    cmd(80'h3700_1800_0000_0000_0600, 6, 64'h0018_0008_1122_0000, 0);
    chk("trunc", {P.q[2], P.q[3]} + 16'h0004 > 16'h0006, 1'b1);
    cmd(80'h3700_1100_0000_0000_0800, 8, 64'h0011_0008_5566_7700, 0);
    chk("count", {P.q[2], P.q[3]} / 16'h0008, 32'h1);
    cmd(80'h3700_0000_0000_0000_6400, 4, 64'h0000_0000_0000_0000, 0);
    cmd(80'h3700_1800_0000_0000_0000, 0, 64'h0, 0);
    av(1'b1, 8'h00, 32'h1);
    cmd(80'h3700_1800_0000_0000_6400, 8, 64'h0010_0004_1122_3344, 0);
    av(1'b1, 8'h00, 32'h3);
  endtask : t_defect
  task t_wbuf;
    for (int m = 1; m < 4; m++)
      cmd({8'h3B, 6'h0, m[1:0], 64'h0}, 0, 64'h0, 1);
    cmd(80'h3B00_0000_0000_0000_4500, 0, 64'h0, 1);
    av(1'b0, 8'h04, 32'h0);
    chk("status", rv, 32'h00003B51);
    cmd(80'h3B00_0000_0000_0000_0600, 0, 64'h0, 0);
    av(1'b1, 8'h18, 32'h0);
    av(1'b0, 8'h1C, 32'h0);
    chk("buf0", rv[7:0], 8'hA4);
    av(1'b1, 8'h18, 32'h1);
    av(1'b0, 8'h1C, 32'h0);
    chk("buf1", rv[7:0], 8'hA5);
    cmd(80'h3700_1800_0000_0000_0000, 0, 64'h0, 0);
    av(1'b1, 8'h18, 32'h0);
    av(1'b0, 8'h1C, 32'h0);
    chk("buf0_next", rv[7:0], 8'h37);
  endtask : t_wbuf
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_defect;
    t_wbuf;
    stop_test;
  end
endmodule : defect_list_and_buffer_cmds_bench
